// File: core/pcl_device.sv
// Configuration device end: reset handshake, one word per link clock, init.
// Assumes the link clock is made by the host and stands still outside loads.
`timescale 1ns/10ps
`default_nettype none
`include "pcl_cfg.svh"
//
// Contract
// - Idle lines high; request low restarts load
// - Status held low through power-on delay
// - Done stays low until image accepted
// - Link clock ignored after load; host drives it
// - Narrow modes use low data bits
// - Data pins become user pins afterwards
// - Full image sent; done only then
// - Two falling edges after done start init
// - Init-complete low until init ends, if enabled
// - Done low within 600 ns of request
// - Status low within 600 ns of request
// - Request low pulse at least 2 us
// - Status low pulse 268 to 1506 us
// - Status released within 1506 us of request
// - First clock 2 us after status rise
// - Clock at most 125/100 MHz, 45% phases
// - Internal init takes 175 to 437 us
// - User clock init: 4 periods, 8576 cycles
// - Ratio-one timing only without decompression/security
// - Higher ratios need faster link clock
module pcl_device #(
  parameter int IMAGE_WORDS = `PCL_IMAGE_WORDS,
  parameter int POR_CYC = `PCL_POR_CYC,
  parameter int STATUS_MIN_CYC = (`PCL_STATUS_MIN_US * 1000 + `PCL_CLK_NS - 1) / `PCL_CLK_NS,
  parameter int INIT_CYC = (`PCL_INIT_MIN_US * 1000 + `PCL_CLK_NS - 1) / `PCL_CLK_NS,
  parameter int USER_INIT_PERIODS = `PCL_USER_INIT_PERIODS
) (
  // System
  input wire logic clk_sys,
  input wire logic reset,
  // Link
  pcl_link_if.dev lnk,
  // Straps and user clock
  input wire pcl_pkg::pcl_width_t width_sel,
  input wire logic user_init_clock,
  // User pins after load
  input wire logic [31:0] user_out,
  input wire logic [31:0] user_oe,
  // Status
  output logic user_mode,
  output logic [1:0] options,
  // Captured words, link clock domain
  output logic [31:0] cfg_word,
  output logic cfg_word_valid
);
  localparam int CU_CYC =
    (`PCL_CU_PERIODS * `PCL_MAX_CLK_PERIOD_NS + `PCL_CLK_NS - 1) / `PCL_CLK_NS;
  localparam int WCW = $clog2(IMAGE_WORDS + 1);
  pcl_pkg::pcl_dev_state_t state_q;
  logic [31:0] cnt_q;
  logic [13:0] ucnt_q;
  logic req_s1, req_s2, ft_s1, ft_s2, et_s1, et_s2, uc_s1, uc_s2, uc_s3;
  logic full_evt, edge_evt, uc_rise;
  logic [1:0] opt_sys_q;
  pcl_pkg::pcl_width_t width_q;
  logic st_oe_q, dn_oe_q, id_oe_q, lclr_q, user_q;
  logic [31:0] pin_o_q, pin_oe_q;
  // Link domain
  logic full_q, edges_q, wv_q;
  logic [1:0] opt_q, fall_cnt_q;
  logic [WCW-1:0] wcnt_q;
  logic [31:0] word_q, masked;

  // Link-side levels stand until the load ends, so two flops carry them safely
  assign full_evt = ft_s2;
  assign edge_evt = et_s2;
  assign uc_rise = uc_s2 && !uc_s3;

  // Crossings into the system domain
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      {req_s1, req_s2} <= 2'h3;
      {ft_s1, ft_s2, et_s1, et_s2} <= 4'h0;
      {uc_s1, uc_s2, uc_s3} <= 3'h0;
    end
    else
    begin
      req_s1 <= lnk.request_n;
      req_s2 <= req_s1;
      ft_s1 <= full_q;
      ft_s2 <= ft_s1;
      et_s1 <= edges_q;
      et_s2 <= et_s1;
      uc_s1 <= user_init_clock;
      uc_s2 <= uc_s1;
      uc_s3 <= uc_s2;
    end
  end

  // Mode strap taken while power-on delay runs
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset) width_q <= pcl_pkg::PCL_W32;
    else if (state_q == pcl_pkg::DS_POR) width_q <= width_sel;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_q <= pcl_pkg::DS_POR;
      cnt_q <= 32'h0;
      ucnt_q <= 14'h0;
      opt_sys_q <= 2'h0;
    end
    else if (!req_s2 && state_q != pcl_pkg::DS_POR && state_q != pcl_pkg::DS_CLEAR)
    begin
      state_q <= pcl_pkg::DS_CLEAR;
      cnt_q <= 32'h0;
    end
    else
    begin
      case (state_q)
        pcl_pkg::DS_POR:
          if (cnt_q == 32'(POR_CYC - 1))
          begin
            state_q <= pcl_pkg::DS_LOAD;
            cnt_q <= 32'h0;
          end
          else cnt_q <= cnt_q + 32'h1;
        pcl_pkg::DS_CLEAR:
          // Status low at least the least pulse, released as soon as request rises after it
          if (req_s2 && cnt_q >= 32'(STATUS_MIN_CYC - 1)) state_q <= pcl_pkg::DS_LOAD;
          else if (cnt_q < 32'(STATUS_MIN_CYC - 1)) cnt_q <= cnt_q + 32'h1;
        pcl_pkg::DS_LOAD:
          if (full_evt)
          begin
            state_q <= pcl_pkg::DS_EDGES;
            opt_sys_q <= opt_q;
          end
        pcl_pkg::DS_EDGES:
          if (edge_evt)
          begin
            state_q <= pcl_pkg::DS_INIT;
            cnt_q <= 32'h0;
            ucnt_q <= 14'h0;
          end
        pcl_pkg::DS_INIT:
          if (opt_sys_q[`PCL_OPT_USER_CLK_BIT])
          begin
            if (cnt_q < 32'(CU_CYC - 1)) cnt_q <= cnt_q + 32'h1;
            else if (uc_rise)
            begin
              if (ucnt_q == 14'(USER_INIT_PERIODS - 1)) state_q <= pcl_pkg::DS_USER;
              else ucnt_q <= ucnt_q + 14'h1;
            end
          end
          else if (cnt_q == 32'(INIT_CYC - 1)) state_q <= pcl_pkg::DS_USER;
          else cnt_q <= cnt_q + 32'h1;
        pcl_pkg::DS_USER: state_q <= pcl_pkg::DS_USER;
        default: state_q <= pcl_pkg::DS_POR;
      endcase
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st_oe_q <= 1'b1;
      dn_oe_q <= 1'b1;
      id_oe_q <= 1'b0;
      lclr_q <= 1'b1;
      user_q <= 1'b0;
      pin_o_q <= 32'h0;
      pin_oe_q <= 32'h0;
    end
    else
    begin
      st_oe_q <= (state_q == pcl_pkg::DS_POR) || (state_q == pcl_pkg::DS_CLEAR);
      dn_oe_q <= (state_q == pcl_pkg::DS_POR) || (state_q == pcl_pkg::DS_CLEAR)
        || (state_q == pcl_pkg::DS_LOAD);
      id_oe_q <= opt_sys_q[`PCL_OPT_INIT_DONE_BIT]
        && ((state_q == pcl_pkg::DS_EDGES) || (state_q == pcl_pkg::DS_INIT));
      // Link side held cleared outside a load; release comes while its clock stands still
      lclr_q <= !((state_q == pcl_pkg::DS_LOAD) || (state_q == pcl_pkg::DS_EDGES));
      user_q <= (state_q == pcl_pkg::DS_USER);
      pin_o_q <= user_out;
      pin_oe_q <= (state_q == pcl_pkg::DS_USER) ? user_oe : 32'h0;
    end
  end

  // Width strap settles during power-on, long before the link clock first runs
  always_comb
  begin
    case (width_q)
      pcl_pkg::PCL_W8: masked = {24'h0, lnk.data[7:0]};
      pcl_pkg::PCL_W16: masked = {16'h0, lnk.data[15:0]};
      default: masked = lnk.data;
    endcase
  end

  // Ratio one only: no decompression or decryption stage sits in this path
  // The link clock stops between loads, so a synchroniser on it would eat the first words
  always_ff @(posedge lnk.config_clock or posedge lclr_q)
  begin
    if (lclr_q)
    begin
      wcnt_q <= '0;
      full_q <= 1'b0;
      wv_q <= 1'b0;
      word_q <= 32'h0;
      opt_q <= 2'h0;
    end
    else if (!full_q)
    begin
      word_q <= masked;
      wv_q <= 1'b1;
      if (wcnt_q == '0) opt_q <= masked[1:0];
      if (wcnt_q == WCW'(IMAGE_WORDS - 1)) full_q <= 1'b1;
      wcnt_q <= wcnt_q + 1'b1;
    end
    else wv_q <= 1'b0;
  end

  // The fall after the last word plus the host's two extra falls
  always_ff @(negedge lnk.config_clock or posedge lclr_q)
  begin
    if (lclr_q)
    begin
      fall_cnt_q <= 2'h0;
      edges_q <= 1'b0;
    end
    else if (full_q && fall_cnt_q != 2'h3)
    begin
      fall_cnt_q <= fall_cnt_q + 2'h1;
      if (fall_cnt_q == 2'h2) edges_q <= 1'b1;
    end
  end

  assign lnk.status_n_o = 1'b0;
  assign lnk.status_n_oe = st_oe_q;
  assign lnk.done_o = 1'b0;
  assign lnk.done_oe = dn_oe_q;
  assign lnk.init_done_o = 1'b0;
  assign lnk.init_done_oe = id_oe_q;
  assign lnk.data_dev_o = pin_o_q;
  assign lnk.data_dev_oe = pin_oe_q;
  assign user_mode = user_q;
  assign options = opt_sys_q;
  assign cfg_word = word_q;
  assign cfg_word_valid = wv_q;
endmodule // pcl_device
`default_nettype wire

// File: core/pcl_cfg.svh
// Constants of the parallel configuration link: timing figures and option bits.
// Assumes the system clock period given by PCL_CLK_NS.
`ifndef PCL_CFG_SVH
`define PCL_CFG_SVH
`define PCL_CLK_NS 4
`define PCL_LINE_RESP_NS 600
`define PCL_REQ_LOW_MIN_US 2
`define PCL_STATUS_MIN_US 268
`define PCL_STATUS_MAX_US 1506
`define PCL_ST2CK_MIN_US 2
`define PCL_INIT_MIN_US 175
`define PCL_INIT_MAX_US 437
`define PCL_CU_PERIODS 4
`define PCL_MAX_CLK_PERIOD_NS 10
`define PCL_USER_INIT_PERIODS 8576
`define PCL_POR_CYC 2048
`define PCL_IMAGE_WORDS 16
`define PCL_HALF_CYC 2
`define PCL_OPT_INIT_DONE_BIT 0
`define PCL_OPT_USER_CLK_BIT 1
`endif

// File: core/pcl_pkg.sv
// Types shared by both ends of the parallel configuration link.
// Assumes nothing beyond a SystemVerilog compiler.
package pcl_pkg;
  typedef enum logic [1:0] {
    PCL_W8 = 2'h0,
    PCL_W16 = 2'h1,
    PCL_W32 = 2'h2
  } pcl_width_t;
  typedef enum logic [5:0] {
    DS_POR = 6'h01,
    DS_CLEAR = 6'h02,
    DS_LOAD = 6'h04,
    DS_EDGES = 6'h08,
    DS_INIT = 6'h10,
    DS_USER = 6'h20
  } pcl_dev_state_t;
  typedef enum logic [6:0] {
    HS_IDLE = 7'h01,
    HS_REQ = 7'h02,
    HS_WAIT = 7'h04,
    HS_GAP = 7'h08,
    HS_STREAM = 7'h10,
    HS_TRAIL = 7'h20,
    HS_DONE = 7'h40
  } pcl_host_state_t;
endpackage

// File: core/pcl_link_if.sv
// Link between configuration host and device; resolves the shared pins.
// Assumes pull-ups on status, done and the init-complete line.
`timescale 1ns/10ps
`default_nettype none
interface pcl_link_if;
  logic request_n;
  logic config_clock;
  logic [31:0] data_host_o;
  logic data_host_oe;
  logic status_n_o;
  logic status_n_oe;
  logic done_o;
  logic done_oe;
  logic init_done_o;
  logic init_done_oe;
  logic [31:0] data_dev_o;
  logic [31:0] data_dev_oe;
  logic status_n;
  logic done;
  logic init_done;
  logic [31:0] data;
  // Pulled-up open-drain lines, then data: the host's word while it drives, else the device's enabled pins
  assign status_n = status_n_oe ? status_n_o : 1'b1;
  assign done = done_oe ? done_o : 1'b1;
  assign init_done = init_done_oe ? init_done_o : 1'b1;
  assign data = data_host_oe ? data_host_o : (data_dev_o & data_dev_oe);
  modport dev (
    input request_n, config_clock, data, status_n, done,
    output status_n_o, status_n_oe, done_o, done_oe, init_done_o, init_done_oe,
    output data_dev_o, data_dev_oe
  );
  modport host (
    input status_n, done, init_done, data,
    output request_n, config_clock, data_host_o, data_host_oe
  );
endinterface
`default_nettype wire

// File: core/pcl_host.sv
// Configuration host: requests reconfiguration and streams image words.
// Assumes the user side presents words with valid/ready on clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "pcl_cfg.svh"
module pcl_host #(
  parameter int HALF_CYC = `PCL_HALF_CYC
) (
  // System
  input wire logic clk_sys,
  input wire logic reset,
  // Link
  pcl_link_if.host lnk,
  // Control
  input wire pcl_pkg::pcl_width_t width_sel,
  input wire logic start,
  output logic busy,
  output logic loaded,
  // Word source
  input wire logic [31:0] src_word,
  input wire logic src_valid,
  output logic src_ready
);
  localparam int REQ_CYC = (`PCL_REQ_LOW_MIN_US * 1000 + `PCL_CLK_NS - 1) / `PCL_CLK_NS;
  localparam int GAP_CYC = (`PCL_ST2CK_MIN_US * 1000 + `PCL_CLK_NS - 1) / `PCL_CLK_NS;
  pcl_pkg::pcl_host_state_t state_q;
  logic [15:0] cnt_q;
  logic [15:0] hcnt_q;
  logic st_s1, st_s2, dn_s1, dn_s2;
  logic clk_q, have_q, req_n_q, oe_q, ready_q, busy_q, loaded_q, tcnt_q;
  logic [31:0] data_q;
  logic run, fall, take;

  assign run = (state_q == pcl_pkg::HS_STREAM) || (state_q == pcl_pkg::HS_TRAIL);
  assign fall = run && (hcnt_q == 16'(HALF_CYC - 1)) && clk_q;
  assign take = ready_q && src_valid;

  // Status and done arrive from the far end
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      {st_s1, st_s2, dn_s1, dn_s2} <= 4'h0;
    end
    else
    begin
      st_s1 <= lnk.status_n;
      st_s2 <= st_s1;
      dn_s1 <= lnk.done;
      dn_s2 <= dn_s1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_q <= pcl_pkg::HS_IDLE;
      cnt_q <= 16'h0;
      tcnt_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        pcl_pkg::HS_IDLE, pcl_pkg::HS_DONE:
          if (start)
          begin
            state_q <= pcl_pkg::HS_REQ;
            cnt_q <= 16'h0;
          end
        pcl_pkg::HS_REQ:
          if (cnt_q == 16'(REQ_CYC - 1)) state_q <= pcl_pkg::HS_WAIT;
          else cnt_q <= cnt_q + 16'h1;
        pcl_pkg::HS_WAIT:
          if (st_s2)
          begin
            state_q <= pcl_pkg::HS_GAP;
            cnt_q <= 16'h0;
          end
        pcl_pkg::HS_GAP:
          if (cnt_q == 16'(GAP_CYC - 1)) state_q <= pcl_pkg::HS_STREAM;
          else cnt_q <= cnt_q + 16'h1;
        pcl_pkg::HS_STREAM:
          if (dn_s2)
          begin
            state_q <= pcl_pkg::HS_TRAIL;
            tcnt_q <= 1'b0;
          end
        pcl_pkg::HS_TRAIL:
          if (fall)
          begin
            tcnt_q <= 1'b1;
            if (tcnt_q) state_q <= pcl_pkg::HS_DONE;
          end
        default: state_q <= pcl_pkg::HS_IDLE;
      endcase
    end
  end

  // Divided link clock; low phase stretches while no word is ready
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      clk_q <= 1'b0;
      hcnt_q <= 16'h0;
    end
    else if (!run)
    begin
      clk_q <= 1'b0;
      hcnt_q <= 16'h0;
    end
    else if (hcnt_q == 16'(HALF_CYC - 1))
    begin
      hcnt_q <= 16'h0;
      if (clk_q) clk_q <= 1'b0;
      else if (have_q || state_q == pcl_pkg::HS_TRAIL) clk_q <= 1'b1;
    end
    else hcnt_q <= hcnt_q + 16'h1;
  end

  // Word holding register; a word set HALF_CYC-1 system cycles before the rise meets setup
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      have_q <= 1'b0;
      data_q <= 32'h0;
      ready_q <= 1'b0;
    end
    else
    begin
      if (take)
      begin
        have_q <= 1'b1;
        case (width_sel)
          pcl_pkg::PCL_W8: data_q <= {24'h0, src_word[7:0]};
          pcl_pkg::PCL_W16: data_q <= {16'h0, src_word[15:0]};
          default: data_q <= src_word;
        endcase
      end
      else if (fall || !run) have_q <= 1'b0;
      ready_q <= (state_q == pcl_pkg::HS_STREAM) && !dn_s2 && (have_q ? fall : !take);
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      req_n_q <= 1'b1;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      loaded_q <= 1'b0;
    end
    else
    begin
      req_n_q <= (state_q != pcl_pkg::HS_REQ);
      oe_q <= (state_q == pcl_pkg::HS_STREAM);
      busy_q <= (state_q != pcl_pkg::HS_IDLE) && (state_q != pcl_pkg::HS_DONE);
      loaded_q <= (state_q == pcl_pkg::HS_DONE);
    end
  end

  assign lnk.request_n = req_n_q;
  assign lnk.config_clock = clk_q;
  assign lnk.data_host_o = data_q;
  assign lnk.data_host_oe = oe_q;
  assign busy = busy_q;
  assign loaded = loaded_q;
  assign src_ready = ready_q;
endmodule // pcl_host
`default_nettype wire

// File: sim/pcl_link_properties.sv
// Checker on the configuration link pins, sampled on the system clock.
// Assumes the host makes the link clock from clk_sys and holds request low for 500 cycles.
`timescale 1ns/10ps
`default_nettype none
module pcl_link_chk #(
  parameter int STATUS_MIN = 50
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Link pins
  input wire logic request_n,
  input wire logic config_clock,
  input wire logic status_n,
  input wire logic done,
  input wire logic init_done,
  input wire logic data_host_oe,
  input wire logic [31:0] data_dev_oe
);
  logic [10:0] req_cnt_q;
  logic req_seen_q;
  logic [10:0] st_cnt_q;
  logic ck_seen_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Counters saturate so a long user mode cannot wrap them
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      req_cnt_q <= 11'h0;
      req_seen_q <= 1'b0;
    end
    else if ($fell(request_n))
    begin
      req_cnt_q <= 11'h1;
      req_seen_q <= 1'b1;
    end
    else if (req_cnt_q != 11'h7ff)
      req_cnt_q <= req_cnt_q + 11'h1;
  end
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st_cnt_q <= 11'h0;
      ck_seen_q <= 1'b0;
    end
    else if ($rose(status_n))
    begin
      st_cnt_q <= 11'h1;
      ck_seen_q <= 1'b0;
    end
    else
    begin
      if ($rose(config_clock))
        ck_seen_q <= 1'b1;
      if (st_cnt_q != 11'h7ff)
        st_cnt_q <= st_cnt_q + 11'h1;
    end
  end
  sequence s_req_fall;
    $fell(request_n);
  endsequence
  sequence s_hi2;
    config_clock [*2];
  endsequence
  sequence s_lo2;
    !config_clock [*2];
  endsequence
  AST_DONE_ON_REQ: assert property (s_req_fall |-> ##[0:150] !done)
    else $error("done not pulled low after request");
  AST_STATUS_ON_REQ: assert property (s_req_fall |-> ##[0:150] !status_n)
    else $error("status not pulled low after request");
  AST_REQ_WIDTH: assert property ($rose(request_n) && req_seen_q |-> req_cnt_q >= 11'h1f4)
    else $error("request low pulse too short");
  AST_STATUS_MIN: assert property ($rose(status_n) && req_seen_q |-> req_cnt_q >= STATUS_MIN)
    else $error("status low pulse too short");
  AST_STATUS_REL: assert property ($rose(request_n) |-> ##[1:8] status_n)
    else $error("status not released after request rose");
  AST_DONE_RISE: assert property ($rose(done) |-> status_n && request_n)
    else $error("done rose outside a load");
  AST_DATA_OWN: assert property (data_host_oe |-> data_dev_oe == 32'h0)
    else $error("device drives data while host streams");
  AST_INIT_LOW: assert property (!init_done |-> done)
    else $error("init-complete low without done");
  AST_FIRST_EDGE: assert property ($rose(config_clock) && !ck_seen_q |-> st_cnt_q >= 11'h1f4)
    else $error("first link clock too soon after status");
  AST_CLK_HIGH: assert property ($rose(config_clock) |-> s_hi2)
    else $error("link clock high phase too short");
  AST_CLK_LOW: assert property ($fell(config_clock) |-> s_lo2)
    else $error("link clock low phase too short");
endmodule // pcl_link_chk
`default_nettype wire

// File: sim/tb_top.sv
// Bench joining host and device through the link, with shortened counts.
// Assumes the device straps its width at power-on, so width changes go through reset.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", nm, e, a); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  pcl_pkg::pcl_width_t wsel = pcl_pkg::PCL_W32;
  logic start = 1'b0;
  logic [31:0] src_word = 32'h0;
  logic src_valid = 1'b0;
  logic uic = 1'b0;
  logic [31:0] user_out = 32'h1234_5678;
  logic [31:0] user_oe = 32'hffff_0000;
  logic busy, loaded, src_ready, user_mode, cfg_word_valid;
  logic [1:0] options;
  logic [31:0] cfg_word;
  logic [31:0] got[$];
  int fails = 0;
  int samples_checked = 0;
  pcl_link_if lnk();
  always #2 clk_sys = ~clk_sys;
  // User clock runs free; 40 ns keeps the init wait short
  always #20 uic = ~uic;
  pcl_host pcl_host_inst (.clk_sys(clk_sys), .reset(reset), .lnk(lnk.host), .width_sel(wsel),
    .start(start), .busy(busy), .loaded(loaded), .src_word(src_word), .src_valid(src_valid),
    .src_ready(src_ready));
  pcl_device #(.IMAGE_WORDS(4), .POR_CYC(20), .STATUS_MIN_CYC(50), .INIT_CYC(40),
    .USER_INIT_PERIODS(8)) pcl_device_inst (.clk_sys(clk_sys), .reset(reset),
    .lnk(lnk.dev), .width_sel(wsel), .user_init_clock(uic), .user_out(user_out),
    .user_oe(user_oe), .user_mode(user_mode), .options(options), .cfg_word(cfg_word),
    .cfg_word_valid(cfg_word_valid));
  pcl_link_chk chk (.clk_sys(clk_sys), .reset(reset),
    .request_n(lnk.request_n), .config_clock(lnk.config_clock), .status_n(lnk.status_n),
    .done(lnk.done), .init_done(lnk.init_done), .data_host_oe(lnk.data_host_oe),
    .data_dev_oe(lnk.data_dev_oe));
  // Valid stands a whole link cycle, so the falling edge sees each word once
  always @(negedge lnk.config_clock)
    if (cfg_word_valid === 1'b1)
      got.push_back(cfg_word);
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset(input pcl_pkg::pcl_width_t w);
    int n;
    @(posedge clk_sys);
    #1 reset = 1'b1;
    wsel = w;
    repeat (20) @(posedge clk_sys);
    #1 reset = 1'b0;
    `CHK("status_por", 1'b0, lnk.status_n)
    `CHK("done_por", 1'b0, lnk.done)
    for (n = 0; n < 100 && lnk.status_n !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    `CHK("por_len", 1'b1, n >= 15 && n < 40)
    `CHK("done_after_por", 1'b0, lnk.done)
    `CHK("user_mode_por", 1'b0, user_mode)
  endtask
  task automatic load(input logic [1:0] opt);
    logic [31:0] wv [4];
    logic [31:0] mask;
    logic lo_seen;
    logic took;
    int idx;
    int t;
    int n;
    mask = (wsel == pcl_pkg::PCL_W8) ? 32'h0000_00ff :
      (wsel == pcl_pkg::PCL_W16) ? 32'h0000_ffff : 32'hffff_ffff;
    for (int i = 0; i < 4; i++)
      wv[i] = 32'h8d2b_61f4 ^ (32'h0101_0104 * i);
    wv[0][1:0] = opt;
    got.delete();
    idx = 0;
    t = 0;
    lo_seen = 1'b0;
    @(posedge clk_sys);
    #1 start = 1'b1;
    @(posedge clk_sys);
    #1 start = 1'b0;
    src_word = wv[0];
    src_valid = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK("req_low", 1'b0, lnk.request_n)
    `CHK("done_clear", 1'b0, lnk.done)
    `CHK("status_clear", 1'b0, lnk.status_n)
    `CHK("user_mode_clear", 1'b0, user_mode)
    // Surplus words after a full image are zeros; the device must ignore them
    for (n = 0; n < 5000 && loaded !== 1'b1; n++)
    begin
      // Ready is read between edges, where it stands for the coming edge
      took = (src_ready === 1'b1);
      @(posedge clk_sys);
      #1;
      if (took)
        idx++;
      src_word = (idx < 4) ? wv[idx] : 32'h0;
      if (lnk.done === 1'b1)
        t++;
      if (lnk.init_done === 1'b0)
        lo_seen = 1'b1;
    end
    src_valid = 1'b0;
    `CHK("loaded", 1'b1, loaded)
    `CHK("done_high", 1'b1, lnk.done)
    `CHK("words", 32'h4, got.size())
    for (int i = 0; i < 4 && i < got.size(); i++)
      `CHK("word", wv[i] & mask, got[i])
    for (n = 0; n < 1000 && user_mode !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1 t++;
      if (lnk.init_done === 1'b0)
        lo_seen = 1'b1;
    end
    if (opt[1])
      `CHK("uclk_init", 1'b1, t >= 80)
    else
      `CHK("osc_init", 1'b1, t >= 40 && t <= 120)
    `CHK("init_pin", opt[0], lo_seen)
    `CHK("options", opt, options)
    `CHK("user_mode", 1'b1, user_mode)
    `CHK("user_pins", user_out & user_oe, lnk.data)
    $display("load done width %0d opt %0d", wsel, opt);
  endtask
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    $display("[ERR] watchdog exp finish got timeout");
    test_done();
  end
  initial
  begin
    do_reset(pcl_pkg::PCL_W32);
    load(2'h0);
    `CHK("idle_status", 1'b1, lnk.status_n)
    `CHK("idle_done", 1'b1, lnk.done)
    user_out = 32'h9abc_def0;
    user_oe = 32'h00ff_ff00;
    load(2'h1);
    do_reset(pcl_pkg::PCL_W16);
    load(2'h2);
    do_reset(pcl_pkg::PCL_W8);
    load(2'h3);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
